// ==== hdl/gcd_dispatch.v ====
// Graphics command FIFO and mode-dependent dispatcher with APB slave
`timescale 1ns/1ns
// Function
// - Frame-buffer write starts mode-selected operation
// - Command register write uses register address
// - Line mode slope/span write: init, draw 16
// - Slope-init-only write initialises engine only
// - Line mode continue extends line 16 pixels
// - Other modes: continue starts mode operation
// - Copy source command fills 64 bytes
// - Copy destination command drains 64 bytes
// - Indirect copy commands use pixel address
// - Copy mode fb write fills or drains
// - Stipple modes draw 32-pixel patterned spans
// - Fill modes fill spans up to 2K
// - Line modes fb write draws 16 pixels
// - DMA copy moves up to 8KB
// - Scaled copy moves up to 4KB
// - 64-entry command FIFO, one packet at a time
// - Next packet waits for previous completion
// - Control registers are double-buffered
// - Busy flag at status bit 0
// - Status write queued, acts as barrier
`include "gcd_defines.vh"

module gcd_dispatch #(
    parameter AW = 24, // APB address width, top bit selects frame buffer
    parameter DEPTH = 64, // Command FIFO entries
    parameter FAW = 6 // FIFO pointer width
) (
    input wire clock, // Core clock
    input wire rst, // Asynchronous reset, active high
    input wire psel, // APB select
    input wire penable, // APB enable
    input wire pwrite, // APB direction
    input wire [AW-1:0] paddr, // APB byte address
    input wire [31:0] pwdata, // APB write data
    output reg [31:0] prdata, // APB read data
    output reg pready, // APB ready
    output reg pslverr, // APB error, unmapped address
    output reg op_valid, // Operation offered to engines
    input wire op_ready, // Engines accept operation
    input wire op_done, // Engines finished accepted operation
    input wire eng_busy, // Engines still processing
    output reg [3:0] op_code, // Operation code
    output reg [3:0] op_mode, // Mode variant for the engines
    output reg [AW-1:0] op_addr, // Frame-buffer byte address
    output reg [31:0] op_data, // Write data of the initiating write
    output reg [13:0] op_count, // Span limit in pixels or bytes
    output reg [2:0] op_slope, // Slope register index
    output reg [31:0] op_fg, // Active foreground colour
    output reg [31:0] op_bg, // Active background colour
    output reg op_bpp32, // Active 32 bpp destination
    output reg busy // Busy flag
);

// ==========================================
// Dispatcher states
localparam S_IDLE = 2'b00;
localparam S_ISSUE = 2'b01;
localparam S_WAIT = 2'b10;
localparam S_BAR = 2'b11;
localparam EW = AW - 2 + 32;

reg [EW-1:0] fifo_mem [0:DEPTH-1];
reg [FAW-1:0] wp_q;
reg [FAW-1:0] rp_q;
reg [FAW:0] cnt_q;
reg [1:0] st_q;
reg [1:0] st_d;
reg [3:0] mode_q;
reg adrsel_q;
reg [31:0] padr_q;
reg [31:0] span_q;
reg [31:0] fg_q;
reg [31:0] bg_q;
reg [31:0] deep_q;
reg copy_full_q;
reg [31:0] rd_d;
reg mapped;
reg launch;
reg barrier;
reg ctl_wr;
reg tog;
reg [3:0] code_d;
reg [13:0] n_d;
reg [AW-1:0] a_d;
reg [3:0] m_code;
reg [13:0] m_n;
reg m_tog;

// ==========================================
// APB side: decode and FIFO push
wire acc = psel && penable && !pready;
wire is_fb = paddr[AW-1];
wire [11:0] off = paddr[11:0];
wire [11:0] grp = off & `GCD_GRP_MASK;
wire full = (cnt_q == DEPTH[FAW:0]);
wire push = acc && pwrite && mapped && !full;

// Map check; the slope groups are eight words each
always @* begin
    mapped = is_fb || grp == `GCD_SLOPE_OFS || grp == `GCD_SNOGO_OFS;
    case (off)
    `GCD_MODE_OFS, `GCD_SPAN_OFS, `GCD_CONT_OFS, `GCD_PADR_OFS,
    `GCD_CSRC_OFS, `GCD_CDST_OFS, `GCD_CSRI_OFS, `GCD_CDSI_OFS,
    `GCD_STAT_OFS, `GCD_DEEP_OFS, `GCD_FG_OFS, `GCD_BG_OFS: begin
        mapped = 1'b1;
    end
    default: begin
    end
    endcase
end

// Read mux shows the loading copies and live status
always @* begin
    rd_d = 32'h0000_0000;
    if (!is_fb) begin
        case (off)
        `GCD_MODE_OFS: begin
            rd_d[`GCD_MODE_MSB:0] = mode_q;
            rd_d[`GCD_ADRSEL_BIT] = adrsel_q;
        end
        `GCD_SPAN_OFS: rd_d = span_q;
        `GCD_PADR_OFS: rd_d = padr_q;
        `GCD_DEEP_OFS: rd_d = deep_q;
        `GCD_FG_OFS: rd_d = fg_q;
        `GCD_BG_OFS: rd_d = bg_q;
        `GCD_STAT_OFS: begin
            rd_d[`GCD_BUSY_BIT] = busy;
            rd_d[`GCD_LVL_LSB+FAW:`GCD_LVL_LSB] = cnt_q;
        end
        default: begin
        end
        endcase
    end
end

// One wait state per transfer; a write stalls while the FIFO is full
always @(posedge clock or posedge rst) begin
    if (rst) begin
        pready <= 1'b0;
        pslverr <= 1'b0;
        prdata <= 32'h0000_0000;
    end else begin
        pready <= acc && (!pwrite || !mapped || !full);
        pslverr <= acc && !mapped;
        if (acc && !pwrite) begin
            prdata <= rd_d;
        end
    end
end

// ==========================================
// Command FIFO: every mapped write is queued in order
wire [EW-1:0] ent = fifo_mem[rp_q];
wire e_fb = ent[EW-1];
wire [AW-1:0] e_adr = {ent[EW-1:32], 2'b00};
wire [11:0] e_off = e_adr[11:0];
wire [11:0] e_grp = e_off & `GCD_GRP_MASK;
wire [31:0] e_dat = ent[31:0];
wire pop = (st_q == S_IDLE) && (cnt_q != {(FAW+1){1'b0}});

// Storage carries no reset; pointers do
always @(posedge clock) begin
    if (push) begin
        fifo_mem[wp_q] <= {paddr[AW-1:2], pwdata};
    end
end

always @(posedge clock or posedge rst) begin
    if (rst) begin
        wp_q <= {FAW{1'b0}};
        rp_q <= {FAW{1'b0}};
        cnt_q <= {(FAW+1){1'b0}};
    end else begin
        if (push) begin
            wp_q <= wp_q + 1'b1;
        end
        if (pop) begin
            rp_q <= rp_q + 1'b1;
        end
        if (push && !pop) begin
            cnt_q <= cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end
end

// ==========================================
// Operation chosen by the current mode; copy mode also uses the copy state and the depth register
wire line_m = (mode_q == `GCD_M_OLINE) || (mode_q == `GCD_M_TLINE);
always @* begin
    m_code = `GCD_OP_WRITE;
    m_n = `GCD_N_SIMPLE;
    m_tog = 1'b0;
    if (mode_q >= `GCD_M_OSTIP && mode_q <= `GCD_M_TRPM) begin
        m_code = `GCD_OP_STIPPLE;
        m_n = `GCD_N_STIP;
    end else if (mode_q >= `GCD_M_OFILL && mode_q <= `GCD_M_TXFILL) begin
        m_code = `GCD_OP_FILL;
        m_n = `GCD_N_FILL;
    end else if (line_m) begin
        m_code = `GCD_OP_LINE;
        m_n = `GCD_N_LINE;
    end else if (mode_q == `GCD_M_COPY) begin
        // Copy hardware state picks fill or drain
        m_code = copy_full_q ? `GCD_OP_CDRAIN : `GCD_OP_CFILL;
        m_n = deep_q[`GCD_BPP32_BIT] ? `GCD_N_C32 : `GCD_N_C8;
        m_tog = 1'b1;
    end else if (mode_q == `GCD_M_DMA) begin
        m_code = `GCD_OP_DMA;
        m_n = `GCD_N_DMA;
    end else if (mode_q == `GCD_M_SCALED) begin
        m_code = `GCD_OP_SCALED;
        m_n = `GCD_N_SCALED;
    end
end

// ==========================================
// Decode of the entry at the FIFO head
always @* begin
    launch = 1'b0;
    barrier = 1'b0;
    ctl_wr = 1'b0;
    tog = 1'b0;
    code_d = m_code;
    n_d = m_n;
    a_d = padr_q[AW-1:0];
    if (e_fb) begin
        launch = 1'b1;
        tog = m_tog;
        a_d = e_adr;
    end else if (e_grp == `GCD_SLOPE_OFS || e_off == `GCD_SPAN_OFS) begin
        launch = line_m;
        code_d = `GCD_OP_LINE;
        n_d = `GCD_N_LINE;
    end else if (e_grp == `GCD_SNOGO_OFS) begin
        launch = line_m;
        code_d = `GCD_OP_LINIT;
        n_d = 14'h0000;
    end else begin
        case (e_off)
        `GCD_CONT_OFS: begin
            launch = 1'b1;
            tog = m_tog && !line_m;
            if (line_m) begin
                code_d = `GCD_OP_LCONT;
                a_d = op_addr;
            end else if (!adrsel_q) begin
                a_d = op_addr;
            end
        end
        `GCD_CSRC_OFS, `GCD_CDST_OFS: begin
            launch = (mode_q == `GCD_M_COPY);
            a_d = e_dat[AW-1:0];
            n_d = `GCD_N_C64;
            code_d = (e_off == `GCD_CSRC_OFS) ?
                `GCD_OP_CFILL : `GCD_OP_CDRAIN;
        end
        `GCD_CSRI_OFS, `GCD_CDSI_OFS: begin
            launch = (mode_q == `GCD_M_COPY);
            n_d = `GCD_N_C64;
            code_d = (e_off == `GCD_CSRI_OFS) ?
                `GCD_OP_CFILL : `GCD_OP_CDRAIN;
        end
        `GCD_STAT_OFS: barrier = 1'b1;
        default: ctl_wr = 1'b1;
        endcase
    end
end

// ==========================================
// Loading copies of the control registers; the active copies are
// the op_* outputs, taken only when an operation launches
always @(posedge clock or posedge rst) begin
    if (rst) begin
        mode_q <= `GCD_M_SIMPLE;
        adrsel_q <= 1'b0;
        padr_q <= 32'h0000_0000;
        span_q <= 32'h0000_0000;
        fg_q <= 32'h0000_0000;
        bg_q <= 32'h0000_0000;
        deep_q <= 32'h0000_0000;
        copy_full_q <= 1'b0;
    end else if (pop) begin
        if (ctl_wr) begin
            case (e_off)
            `GCD_MODE_OFS: begin
                mode_q <= e_dat[`GCD_MODE_MSB:0];
                adrsel_q <= e_dat[`GCD_ADRSEL_BIT];
            end
            `GCD_PADR_OFS: padr_q <= e_dat;
            `GCD_FG_OFS: fg_q <= e_dat;
            `GCD_BG_OFS: bg_q <= e_dat;
            `GCD_DEEP_OFS: deep_q <= e_dat;
            default: begin
            end
            endcase
        end
        if (!e_fb && e_off == `GCD_SPAN_OFS) begin
            span_q <= e_dat;
        end
        // Copy commands set the copy state explicitly
        if (launch && code_d == `GCD_OP_CFILL && !tog) begin
            copy_full_q <= 1'b1;
        end else if (launch && code_d == `GCD_OP_CDRAIN && !tog) begin
            copy_full_q <= 1'b0;
        end else if (launch && tog) begin
            copy_full_q <= !copy_full_q;
        end
    end
end

// ==========================================
// Dispatcher state machine
always @* begin
    st_d = st_q;
    case (st_q)
    S_IDLE: begin
        if (pop && launch) begin
            st_d = S_ISSUE;
        end else if (pop && barrier) begin
            st_d = S_BAR;
        end
    end
    S_ISSUE: begin
        if (op_ready) begin
            st_d = S_WAIT;
        end
    end
    S_WAIT: begin
        if (op_done) begin
            st_d = S_IDLE;
        end
    end
    S_BAR: begin
        if (!eng_busy) begin
            st_d = S_IDLE;
        end
    end
    default: st_d = S_IDLE;
    endcase
end

// Operation outputs latch the active parameter set at launch
always @(posedge clock or posedge rst) begin
    if (rst) begin
        st_q <= S_IDLE;
        op_valid <= 1'b0;
        op_code <= `GCD_OP_WRITE;
        op_mode <= `GCD_M_SIMPLE;
        op_addr <= {AW{1'b0}};
        op_data <= 32'h0000_0000;
        op_count <= 14'h0000;
        op_slope <= 3'h0;
        op_fg <= 32'h0000_0000;
        op_bg <= 32'h0000_0000;
        op_bpp32 <= 1'b0;
        busy <= 1'b0;
    end else begin
        st_q <= st_d;
        op_valid <= (st_d == S_ISSUE);
        if (pop && launch) begin
            op_code <= code_d;
            op_mode <= mode_q;
            op_addr <= a_d;
            op_data <= e_dat;
            op_count <= n_d;
            op_slope <= e_off[4:2];
            op_fg <= fg_q;
            op_bg <= bg_q;
            op_bpp32 <= deep_q[`GCD_BPP32_BIT];
        end
        // Lags the FIFO by one cycle, so a poll right after a write
        // may still see idle; the barrier write avoids that race
        busy <= (cnt_q != {(FAW+1){1'b0}}) || (st_d != S_IDLE) ||
            eng_busy;
    end
end

endmodule // gcd_dispatch

// ==== common/gcd_defines.vh ====
// Address map, mode codes and operation codes of the command dispatcher
`ifndef GCD_DEFINES_VH
`define GCD_DEFINES_VH
// ==========================================
// Register byte offsets in register space
`define GCD_GRP_MASK 12'hFE0
`define GCD_MODE_OFS 12'h000
`define GCD_SLOPE_OFS 12'h020
`define GCD_SPAN_OFS 12'h040
`define GCD_SNOGO_OFS 12'h060
`define GCD_CONT_OFS 12'h080
`define GCD_PADR_OFS 12'h084
`define GCD_CSRC_OFS 12'h088
`define GCD_CDST_OFS 12'h08C
`define GCD_CSRI_OFS 12'h090
`define GCD_CDSI_OFS 12'h094
`define GCD_STAT_OFS 12'h098
`define GCD_DEEP_OFS 12'h09C
`define GCD_FG_OFS 12'h0A0
`define GCD_BG_OFS 12'h0A4
// ==========================================
// Field positions
`define GCD_MODE_MSB 3
`define GCD_ADRSEL_BIT 8
`define GCD_BUSY_BIT 0
`define GCD_LVL_LSB 8
`define GCD_BPP32_BIT 0
// ==========================================
// Drawing modes held in mode_select_reg
`define GCD_M_SIMPLE 4'h0
`define GCD_M_OSTIP 4'h1
`define GCD_M_TRPM 4'h6
`define GCD_M_OFILL 4'h7
`define GCD_M_TXFILL 4'hA
`define GCD_M_OLINE 4'hB
`define GCD_M_TLINE 4'hC
`define GCD_M_COPY 4'hD
`define GCD_M_DMA 4'hE
`define GCD_M_SCALED 4'hF
// ==========================================
// Operation codes sent to the pixel engines
`define GCD_OP_WRITE 4'h0
`define GCD_OP_STIPPLE 4'h1
`define GCD_OP_FILL 4'h2
`define GCD_OP_LINE 4'h3
`define GCD_OP_LINIT 4'h4
`define GCD_OP_LCONT 4'h5
`define GCD_OP_CFILL 4'h6
`define GCD_OP_CDRAIN 4'h7
`define GCD_OP_DMA 4'h8
`define GCD_OP_SCALED 4'h9
// ==========================================
// Span limits: pixels, or bytes for copy-64, DMA and scaled copy
`define GCD_N_SIMPLE 14'h0004
`define GCD_N_STIP 14'h0020
`define GCD_N_LINE 14'h0010
`define GCD_N_FILL 14'h0800
`define GCD_N_C64 14'h0040
`define GCD_N_C8 14'h0020
`define GCD_N_C32 14'h0010
`define GCD_N_DMA 14'h2000
`define GCD_N_SCALED 14'h1000
`endif

// ==== sim/gcd_dispatch_properties.sv ====
// Port assertions for the graphics command dispatcher
`timescale 1ns/1ns
`include "gcd_defines.vh"
module gcd_dispatch_properties (
    input wire clock, // Core clock
    input wire rst, // Reset
    input wire psel, // Select
    input wire penable, // Enable
    input wire pwrite, // Direction
    input wire pready, // Ready
    input wire pslverr, // Error
    input wire op_valid, // Op offered
    input wire op_ready, // Op taken
    input wire op_done, // Op finished
    input wire [3:0] op_code, // Op code
    input wire [23:0] op_addr, // Op address
    input wire [13:0] op_count, // Span limit
    input wire busy // Busy flag
);
    reg out_q;
    reg [13:0] exp_n;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    // ==========================================
    // Helpers
    // One accepted operation may be outstanding at the engines
    always @(posedge clock or posedge rst)
        if (rst)
            out_q <= 1'b0;
        else if (op_valid && op_ready)
            out_q <= 1'b1;
        else if (op_done)
            out_q <= 1'b0;
    // Fixed span limits; copy spans depend on the source and are skipped
    always @* begin
        case (op_code)
            `GCD_OP_STIPPLE: exp_n = `GCD_N_STIP;
            `GCD_OP_FILL: exp_n = `GCD_N_FILL;
            `GCD_OP_LINE, `GCD_OP_LCONT: exp_n = `GCD_N_LINE;
            `GCD_OP_DMA: exp_n = `GCD_N_DMA;
            `GCD_OP_SCALED: exp_n = `GCD_N_SCALED;
            default: exp_n = 14'h0000;
        endcase
    end
    // ==========================================
    // Properties
    ready_pulse_a:
    assert property (pready |=> !pready) else $error("long pready");
    err_ready_a:
    assert property (pslverr |-> pready) else $error("stray pslverr");
    read_answer_a:
    assert property (psel && penable && !pwrite && !pready |=> pready)
        else $error("slow read");
    push_busy_a:
    assert property (psel && penable && pwrite && pready && !pslverr
        |-> ##[0:1] busy) else $error("busy missing");
    op_hold_a:
    assert property (op_valid && !op_ready |=> op_valid && $stable(op_code)
        && $stable(op_addr) && $stable(op_count)) else $error("op dropped");
    single_op_a:
    assert property (!(out_q && op_valid)) else $error("second op");
    exec_busy_a:
    assert property (out_q || op_valid |-> busy) else $error("idle flag");
    span_limit_a:
    assert property (op_valid && exp_n != 14'h0000 |-> op_count == exp_n)
        else $error("span limit");
    restart_gap_a:
    assert property (op_done && out_q |=> !op_valid) else $error("early op");
endmodule // gcd_dispatch_properties
bind gcd_dispatch gcd_dispatch_properties u_props (.clock(clock),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pready(pready), .pslverr(pslverr), .op_valid(op_valid),
    .op_ready(op_ready), .op_done(op_done), .op_code(op_code),
    .op_addr(op_addr), .op_count(op_count), .busy(busy));

// ==== sim/gcd_engine_model.sv ====
// Behavioural pixel engines that take and finish dispatched operations
`timescale 1ns/1ns
module gcd_engine_model (
    input wire clock, // Core clock
    input wire rst, // Reset, active high
    input wire hold, // Refuse new operations
    input wire [2:0] lat, // Extra cycles per operation
    input wire op_valid, // Operation offered
    output reg op_ready, // Operation taken
    output reg op_done, // Completion pulse
    output reg eng_busy // Operation running
);
    reg [2:0] cnt_q;
    // ==========================================
    // Engine
    // Ready drops on acceptance so a second offer is never taken early
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            op_ready <= 1'b0;
            op_done <= 1'b0;
            eng_busy <= 1'b0;
            cnt_q <= 3'h0;
        end else begin
            op_done <= 1'b0;
            op_ready <= !hold && !eng_busy && !(op_valid && op_ready);
            if (op_valid && op_ready) begin
                eng_busy <= 1'b1;
                cnt_q <= lat;
            end else if (eng_busy && cnt_q == 3'h0) begin
                eng_busy <= 1'b0;
                op_done <= 1'b1;
            end else if (eng_busy)
                cnt_q <= cnt_q - 3'h1;
        end
    end
endmodule // gcd_engine_model

// ==== sim/test_graphics_command_dispatch.sv ====
// Self-checking bench for the graphics command dispatcher
`timescale 1ns/1ns
`include "gcd_defines.vh"
module test_graphics_command_dispatch;
    reg clock = 1'b0;
    reg rst = 1'b1;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [23:0] paddr = 24'h00_0000;
    reg [31:0] pwdata = 32'h0000_0000;
    reg hold = 1'b0;
    reg [2:0] lat = 3'h0;
    wire [31:0] prdata;
    wire pready, pslverr, op_valid, op_ready, op_done, eng_busy, busy;
    wire [3:0] op_code;
    wire [23:0] op_addr;
    wire [13:0] op_count;
    wire [2:0] op_slope;
    wire [3:0] op_mode;
    wire [31:0] op_data, op_fg, op_bg;
    wire op_bpp32;
    reg [31:0] dv, fv, gv;
    reg [43:0] oq[$];
    reg [43:0] last;
    reg [31:0] rv;
    reg re;
    reg [22:0] a;
    reg [22:0] p;
    integer err_total = 0;
    integer n_checks = 0;
    integer i;
    gcd_dispatch u_gcd_dispatch (.clock(clock), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .op_valid(op_valid), .op_ready(op_ready), .op_done(op_done),
        .eng_busy(eng_busy), .op_code(op_code), .op_mode(op_mode),
        .op_addr(op_addr), .op_data(op_data), .op_count(op_count),
        .op_slope(op_slope), .op_fg(op_fg), .op_bg(op_bg),
        .op_bpp32(op_bpp32), .busy(busy));
    gcd_engine_model u_gcd_engine_model (.clock(clock), .rst(rst),
        .hold(hold), .lat(lat), .op_valid(op_valid), .op_ready(op_ready),
        .op_done(op_done), .eng_busy(eng_busy));
    // ==========================================
    // Clock, watchdog, monitor and helpers
    always #10 clock = ~clock;
    // A hang ends the run through the normal verdict
    initial begin
        #800000;
        err_total = err_total + 1;
        give_verdict;
    end
    // Record every accepted operation; design outputs change by NBA
    always @(posedge clock)
        if (op_valid === 1'b1 && op_ready === 1'b1)
            oq.push_back({op_code, op_count, op_slope, op_addr[22:0]});
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task cmp(input string what, input [31:0] exp, input [31:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until the edge where pready is seen high
    task apb(input w, input [23:0] ad, input [31:0] d);
        integer k;
        k = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        // Ready and the answer are taken at rising edges only
        @(posedge clock);
        while (pready !== 1'b1 && k < 500) begin
            @(posedge clock);
            k = k + 1;
        end
        cmp("apb answer", 1, k < 500);
        rv = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input [23:0] ad, input [31:0] d);
        apb(1'b1, ad, d);
    endtask
    task rd(input [23:0] ad);
        apb(1'b0, ad, 32'h0000_0000);
    endtask
    function [3:0] fn_op(input [3:0] m);
        if (m == `GCD_M_SIMPLE)
            fn_op = `GCD_OP_WRITE;
        else if (m < `GCD_M_OFILL)
            fn_op = `GCD_OP_STIPPLE;
        else if (m < `GCD_M_OLINE)
            fn_op = `GCD_OP_FILL;
        else if (m < `GCD_M_COPY)
            fn_op = `GCD_OP_LINE;
        else
            fn_op = (m == `GCD_M_DMA) ? `GCD_OP_DMA : `GCD_OP_SCALED;
    endfunction
    function [13:0] fn_cnt(input [3:0] c);
        case (c)
            `GCD_OP_STIPPLE: fn_cnt = 14'h0020;
            `GCD_OP_FILL: fn_cnt = 14'h0800;
            `GCD_OP_LINE, `GCD_OP_LCONT: fn_cnt = 14'h0010;
            `GCD_OP_DMA: fn_cnt = 14'h2000;
            `GCD_OP_SCALED: fn_cnt = 14'h1000;
            default: fn_cnt = 14'h0004;
        endcase
    endfunction
    // Count 3fff skips the span, ca=0 skips the address
    task exp_op(input [3:0] c, input [13:0] n, input [22:0] ad, input ca);
        integer k;
        k = 0;
        while (oq.size() == 0 && k < 400) begin
            @(negedge clock);
            k = k + 1;
        end
        if (oq.size() == 0)
            cmp("op present", 1, 0);
        else begin
            last = oq.pop_front();
            cmp("op code", c, last[43:40]);
            if (n !== 14'h3fff)
                cmp("op count", n, last[39:26]);
            if (ca)
                cmp("op addr", ad, last[22:0]);
        end
    endtask
    // ==========================================
    // Tests
    initial begin
        rv = $urandom(44);
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        rd(`GCD_STAT_OFS);
        cmp("status busy", 0, rv[0]);
        fv = $urandom;
        gv = $urandom;
        wr(`GCD_FG_OFS, fv);
        wr(`GCD_BG_OFS, gv);
        // Every mode on a frame-buffer write, copy mode apart
        for (i = 0; i < 16; i = i + 1) begin
            if (i != `GCD_M_COPY) begin
                lat <= 3'($urandom);
                a = 23'($urandom) & 23'h7f_fff8;
                dv = $urandom;
                wr(`GCD_MODE_OFS, i);
                wr({1'b1, a}, dv);
                exp_op(fn_op(i), fn_cnt(fn_op(i)), a, 1);
                cmp("op data", dv, op_data);
                cmp("op mode", i, op_mode);
                cmp("op fg", fv, op_fg);
                cmp("op bg", gv, op_bg);
            end
        end
        $display("test modes done"); // above
        p = 23'($urandom) & 23'h7f_fff8;
        a = 23'($urandom) & 23'h7f_fff8;
        wr(`GCD_MODE_OFS, `GCD_M_COPY);
        wr(`GCD_PADR_OFS, p);
        wr({1'b1, a}, 32'h0000_ffff);
        exp_op(`GCD_OP_CFILL, 14'h0020, a, 1);
        wr({1'b1, a}, 32'h0000_ffff);
        exp_op(`GCD_OP_CDRAIN, 14'h0020, a, 1);
        wr(`GCD_CSRC_OFS, a);
        exp_op(`GCD_OP_CFILL, 14'h0040, a, 1);
        wr(`GCD_CDST_OFS, a);
        exp_op(`GCD_OP_CDRAIN, 14'h0040, a, 1);
        wr(`GCD_CSRI_OFS, 32'h0000_0000);
        exp_op(`GCD_OP_CFILL, 14'h0040, p, 1);
        wr(`GCD_CDSI_OFS, 32'h0000_0000);
        exp_op(`GCD_OP_CDRAIN, 14'h0040, p, 1);
        // The host polls until idle before touching the deep register
        rd(`GCD_STAT_OFS);
        for (i = 0; i < 50 && rv[0] !== 1'b0; i = i + 1)
            rd(`GCD_STAT_OFS);
        cmp("idle before deep", 0, rv[0]);
        wr(`GCD_DEEP_OFS, 32'h0000_0001);
        wr({1'b1, a}, 32'h0000_ffff);
        exp_op(`GCD_OP_CFILL, 14'h0010, a, 1);
        cmp("op bpp32", 1, op_bpp32);
        $display("test copy done");
        wr(`GCD_MODE_OFS, `GCD_M_OLINE);
        for (i = 0; i < 8; i = i + 1) begin
            wr(`GCD_SLOPE_OFS + 4 * i, $urandom);
            exp_op(`GCD_OP_LINE, 14'h0010, p, 0);
            cmp("op slope", i, last[25:23]);
            wr(`GCD_SNOGO_OFS + 4 * i, $urandom);
            exp_op(`GCD_OP_LINIT, 14'h3fff, p, 0);
        end
        wr(`GCD_SPAN_OFS, $urandom);
        exp_op(`GCD_OP_LINE, 14'h0010, p, 0);
        a = last[22:0];
        wr(`GCD_CONT_OFS, $urandom);
        exp_op(`GCD_OP_LCONT, 14'h0010, a, 1);
        wr(`GCD_MODE_OFS, 32'h0000_0101);
        wr(`GCD_CONT_OFS, $urandom);
        exp_op(`GCD_OP_STIPPLE, 14'h0020, p, 1);
        $display("test commands done");
        // Engines stalled: one op offered, 64 queued behind it
        hold <= 1'b1;
        wr(`GCD_MODE_OFS, `GCD_M_SIMPLE);
        for (i = 0; i < 65; i = i + 1)
            wr({1'b1, 23'(i * 8)}, i);
        rd(`GCD_STAT_OFS);
        cmp("fifo level", 64, rv[14:8]);
        cmp("status busy", 1, rv[0]);
        hold <= 1'b0;
        for (i = 0; i < 65; i = i + 1)
            exp_op(`GCD_OP_WRITE, 14'h0004, 23'(i * 8), 1);
        lat <= 3'h7;
        wr({1'b1, a}, 32'h0000_0001);
        // A new colour queued behind a running op must not reach it
        wr(`GCD_FG_OFS, ~fv);
        cmp("fg held", fv, op_fg);
        wr(`GCD_STAT_OFS, 32'h0000_0000);
        rd(`GCD_STAT_OFS);
        cmp("barrier busy", 1, rv[0]);
        exp_op(`GCD_OP_WRITE, 14'h0004, a, 1);
        rd(24'h00_0f00);
        cmp("unmapped error", 1, re);
        $display("test queue done");
        give_verdict;
    end
endmodule // test_graphics_command_dispatch
